// ### hdl/timer5_compare_irq_regs.sv
`default_nettype none
module timer5_compare_irq_regs
  import timer5_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Counter side
  input wire logic timer_tick,
  input wire logic [15:0] counter_value,
  input wire logic counter_write,
  input wire logic overflow_event,
  input wire logic limit_event,
  input wire logic [3:0] waveform_mode_field,
  input wire logic [2:0] force_match,
  output logic [2:0] match_out,
  // Interrupt controller
  input wire logic global_irq_enable,
  input wire logic [3:0] vector_ack,
  output logic [3:0] irq_request,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] temp_high;
  logic [15:0] match_value_a;
  logic [15:0] match_value_b;
  logic [15:0] match_value_c;
  logic [15:0] capture_value;
  logic [7:0] event_enables;
  logic [7:0] event_flags;
  logic [2:0] match_hit;
  logic match_block;
  logic [2:0] equal_now;
  logic [7:0] next_flags;
  logic [7:0] set_bits;
  logic [7:0] clear_bits;
  logic overflow_set;

  ////////////////////////////////////////////////////////////////////////////
  // Shared high-byte latch
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      temp_high <= RESET_BYTE;
    end else if (reg_write && (reg_addr == OFS_MATCH_A_HIGH || reg_addr == OFS_MATCH_B_HIGH ||
                 reg_addr == OFS_MATCH_C_HIGH)) begin
      temp_high <= reg_wdata;
    end else if (reg_read && reg_addr == OFS_CAPTURE_LOW) begin
      temp_high <= capture_value[15:8];
    end
  end

  // Compare values, low byte commits the pair
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      match_value_a <= RESET_WORD;
      match_value_b <= RESET_WORD;
      match_value_c <= RESET_WORD;
    end else if (reg_write) begin
      unique case (reg_addr)
        OFS_MATCH_A_LOW: match_value_a <= {temp_high, reg_wdata};
        OFS_MATCH_B_LOW: match_value_b <= {temp_high, reg_wdata};
        OFS_MATCH_C_LOW: match_value_c <= {temp_high, reg_wdata};
        default: ;
      endcase
    end
  end

  // No capture input exists, so nothing ever loads it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      capture_value <= RESET_WORD;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      event_enables <= RESET_BYTE;
    end else if (reg_write && reg_addr == OFS_EVENT_ENABLES) begin
      event_enables <= reg_wdata & EVENT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare path
  assign equal_now[0] = (counter_value == match_value_a);
  assign equal_now[1] = (counter_value == match_value_b);
  assign equal_now[2] = (counter_value == match_value_c);

  // One tick of blocking after a counter write
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      match_block <= 1'b0;
    end else if (counter_write) begin
      match_block <= 1'b1;
    end else if (timer_tick) begin
      match_block <= 1'b0;
    end
  end

  // Hits wait one tick before reaching the flags
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      match_hit <= RESET_HITS;
    end else if (timer_tick) begin
      match_hit <= match_block ? RESET_HITS : equal_now;
    end
  end

  assign match_out = match_hit | force_match;

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a set in the same cycle as a clear wins
  always_comb begin
    if (waveform_mode_field == MODE_NORMAL || waveform_mode_field == MODE_CLEAR_ON_MATCH_OCR ||
        waveform_mode_field == MODE_CLEAR_ON_MATCH_ICR) begin
      overflow_set = overflow_event;
    end else begin
      overflow_set = limit_event;
    end
    set_bits = RESET_BYTE;
    set_bits[BIT_OVERFLOW] = overflow_set;
    set_bits[BIT_MATCH_A] = timer_tick & match_hit[0];
    set_bits[BIT_MATCH_B] = timer_tick & match_hit[1];
    set_bits[BIT_MATCH_C] = timer_tick & match_hit[2];
    clear_bits = RESET_BYTE;
    if (reg_write && (reg_addr == OFS_EVENT_FLAGS || reg_addr == OFS_EVENT_CLEAR)) begin
      clear_bits = reg_wdata & EVENT_MASK;
    end
    clear_bits[BIT_OVERFLOW] = clear_bits[BIT_OVERFLOW] | vector_ack[0];
    clear_bits[BIT_MATCH_A] = clear_bits[BIT_MATCH_A] | vector_ack[1];
    clear_bits[BIT_MATCH_B] = clear_bits[BIT_MATCH_B] | vector_ack[2];
    clear_bits[BIT_MATCH_C] = clear_bits[BIT_MATCH_C] | vector_ack[3];
    next_flags = ((event_flags & ~clear_bits) | set_bits) & EVENT_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      event_flags <= RESET_BYTE;
    end else begin
      event_flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests; the capture bits are left out on purpose
  always_comb begin
    irq_request[0] = global_irq_enable & event_enables[BIT_OVERFLOW] & event_flags[BIT_OVERFLOW];
    irq_request[1] = global_irq_enable & event_enables[BIT_MATCH_A] & event_flags[BIT_MATCH_A];
    irq_request[2] = global_irq_enable & event_enables[BIT_MATCH_B] & event_flags[BIT_MATCH_B];
    irq_request[3] = global_irq_enable & event_enables[BIT_MATCH_C] & event_flags[BIT_MATCH_C];
  end

  assign irq = |irq_request;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_read) begin
      unique case (reg_addr)
        OFS_EVENT_FLAGS: reg_rdata <= event_flags & EVENT_MASK;
        OFS_EVENT_ENABLES: reg_rdata <= event_enables & EVENT_MASK;
        OFS_CAPTURE_LOW: reg_rdata <= capture_value[7:0];
        OFS_CAPTURE_HIGH: reg_rdata <= temp_high;
        OFS_MATCH_A_LOW: reg_rdata <= match_value_a[7:0];
        OFS_MATCH_A_HIGH: reg_rdata <= match_value_a[15:8];
        OFS_MATCH_B_LOW: reg_rdata <= match_value_b[7:0];
        OFS_MATCH_B_HIGH: reg_rdata <= match_value_b[15:8];
        OFS_MATCH_C_LOW: reg_rdata <= match_value_c[7:0];
        OFS_MATCH_C_HIGH: reg_rdata <= match_value_c[15:8];
        default: reg_rdata <= RESET_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_compare_hit;
    @(posedge ref_clk) disable iff (!nrst)
    (timer_tick && !match_block && !counter_write && counter_value == match_value_c) |=> match_hit[2];
  endproperty
  a_compare_hit: assert property (p_compare_hit)
    else $error("compare hit missed");

  property p_pair_commit;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_write && reg_addr == OFS_MATCH_A_LOW) |=> match_value_a == {$past(temp_high), $past(reg_wdata)};
  endproperty
  a_pair_commit: assert property (p_pair_commit)
    else $error("compare pair not committed together");

  property p_capture_pair;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_read && reg_addr == OFS_CAPTURE_LOW) ##1 (reg_read && reg_addr == OFS_CAPTURE_HIGH)
      |=> reg_rdata == capture_value[15:8];
  endproperty
  a_capture_pair: assert property (p_capture_pair)
    else $error("capture high byte incoherent");

  property p_capture_zero;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_read && (reg_addr == OFS_CAPTURE_LOW || reg_addr == OFS_CAPTURE_HIGH) && !$past(reg_read))
      |=> reg_rdata == RESET_BYTE;
  endproperty
  a_capture_zero: assert property (p_capture_zero)
    else $error("capture pair not zero");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_read && (reg_addr == OFS_EVENT_FLAGS || reg_addr == OFS_EVENT_ENABLES))
      |=> (reg_rdata[7:6] == 2'b00) && !reg_rdata[4];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit read as one");

  property p_capture_quiet;
    @(posedge ref_clk) disable iff (!nrst)
    (event_enables[BIT_CAPTURE] && global_irq_enable &&
     (event_flags & event_enables & 8'h0f) == RESET_BYTE) |-> !irq;
  endproperty
  a_capture_quiet: assert property (p_capture_quiet)
    else $error("capture bits raised interrupt");

  property p_match_request;
    @(posedge ref_clk) disable iff (!nrst)
    (timer_tick && match_hit[1] && event_enables[BIT_MATCH_B] && global_irq_enable)
      ##1 global_irq_enable |-> irq_request[2] && irq;
  endproperty
  a_match_request: assert property (p_match_request)
    else $error("match request missing");

  property p_overflow_gate;
    @(posedge ref_clk) disable iff (!nrst)
    !global_irq_enable |-> irq_request == 4'h0 && !irq;
  endproperty
  a_overflow_gate: assert property (p_overflow_gate)
    else $error("request without global enable");

  property p_flag_after_tick;
    @(posedge ref_clk) disable iff (!nrst)
    (timer_tick && match_hit[0]) |=> event_flags[BIT_MATCH_A];
  endproperty
  a_flag_after_tick: assert property (p_flag_after_tick)
    else $error("match flag not set");

  property p_force_no_flag;
    @(posedge ref_clk) disable iff (!nrst)
    (force_match[2] && !event_flags[BIT_MATCH_C] && !(timer_tick && match_hit[2])) |=> !event_flags[BIT_MATCH_C];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag)
    else $error("force set a flag");

  property p_vector_clear;
    @(posedge ref_clk) disable iff (!nrst)
    (vector_ack[3] && !(timer_tick && match_hit[2])) |=> !event_flags[BIT_MATCH_C];
  endproperty
  a_vector_clear: assert property (p_vector_clear)
    else $error("vector did not clear match flag");

  property p_write_one_clear;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_write && reg_addr == OFS_EVENT_FLAGS && reg_wdata[BIT_MATCH_B] && !(timer_tick && match_hit[1]))
      |=> !event_flags[BIT_MATCH_B];
  endproperty
  a_write_one_clear: assert property (p_write_one_clear)
    else $error("write one did not clear");

  property p_overflow_normal;
    @(posedge ref_clk) disable iff (!nrst)
    (overflow_event && waveform_mode_field == MODE_NORMAL) |=> event_flags[BIT_OVERFLOW];
  endproperty
  a_overflow_normal: assert property (p_overflow_normal)
    else $error("overflow flag not set");

  property p_overflow_vector;
    @(posedge ref_clk) disable iff (!nrst)
    (vector_ack[0] && !overflow_set) |=> !event_flags[BIT_OVERFLOW];
  endproperty
  a_overflow_vector: assert property (p_overflow_vector)
    else $error("overflow vector did not clear");

  property p_block_after_write;
    @(posedge ref_clk) disable iff (!nrst)
    (counter_write && !timer_tick) ##1 (!counter_write && timer_tick) |=> match_hit == RESET_HITS;
  endproperty
  a_block_after_write: assert property (p_block_after_write)
    else $error("match not blocked after counter write");

  property p_write_zero_keeps;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_write && reg_addr == OFS_EVENT_FLAGS && !reg_wdata[BIT_OVERFLOW] && event_flags[BIT_OVERFLOW] &&
     !vector_ack[0]) |=> event_flags[BIT_OVERFLOW];
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps)
    else $error("write zero cleared a flag");

  property p_reserved_write;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_write && reg_addr == OFS_EVENT_ENABLES) |=> event_enables[7:6] == 2'b00 && !event_enables[4];
  endproperty
  a_reserved_write: assert property (p_reserved_write)
    else $error("reserved enable bit stored");

  property p_overflow_request;
    @(posedge ref_clk) disable iff (!nrst)
    (event_flags[BIT_OVERFLOW] && event_enables[BIT_OVERFLOW] && global_irq_enable) |-> irq_request[0] && irq;
  endproperty
  a_overflow_request: assert property (p_overflow_request)
    else $error("overflow request missing");

  property p_match_a_gate;
    @(posedge ref_clk) disable iff (!nrst)
    !event_enables[BIT_MATCH_A] |-> !irq_request[1];
  endproperty
  a_match_a_gate: assert property (p_match_a_gate)
    else $error("match request without enable");

  property p_flag_c_after_tick;
    @(posedge ref_clk) disable iff (!nrst)
    (timer_tick && match_hit[2]) |=> event_flags[BIT_MATCH_C];
  endproperty
  a_flag_c_after_tick: assert property (p_flag_c_after_tick)
    else $error("match flag c not set");

  property p_overflow_ctc;
    @(posedge ref_clk) disable iff (!nrst)
    (overflow_event && waveform_mode_field == MODE_CLEAR_ON_MATCH_OCR) |=> event_flags[BIT_OVERFLOW];
  endproperty
  a_overflow_ctc: assert property (p_overflow_ctc)
    else $error("overflow flag not set in clear on match");

endmodule
`default_nettype wire

// ### hdl/timer5_pkg.sv
`default_nettype none
package timer5_pkg;
  localparam int ADDR_W = 9;
  // Register offsets
  localparam logic [8:0] OFS_EVENT_FLAGS = 9'h03a;
  localparam logic [8:0] OFS_EVENT_ENABLES = 9'h073;
  localparam logic [8:0] OFS_CAPTURE_LOW = 9'h126;
  localparam logic [8:0] OFS_CAPTURE_HIGH = 9'h127;
  localparam logic [8:0] OFS_MATCH_A_LOW = 9'h128;
  localparam logic [8:0] OFS_MATCH_A_HIGH = 9'h129;
  localparam logic [8:0] OFS_MATCH_B_LOW = 9'h12a;
  localparam logic [8:0] OFS_MATCH_B_HIGH = 9'h12b;
  localparam logic [8:0] OFS_MATCH_C_LOW = 9'h12c;
  localparam logic [8:0] OFS_MATCH_C_HIGH = 9'h12d;
  localparam logic [8:0] OFS_EVENT_CLEAR = 9'h13f;
  // Field positions in flags and enables
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_MATCH_A = 1;
  localparam int BIT_MATCH_B = 2;
  localparam int BIT_MATCH_C = 3;
  localparam int BIT_CAPTURE = 5;
  localparam logic [7:0] EVENT_MASK = 8'h2f;
  // Values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [2:0] RESET_HITS = 3'h0;
  // Waveform modes with a plain overflow
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLEAR_ON_MATCH_OCR = 4'h4;
  localparam logic [3:0] MODE_CLEAR_ON_MATCH_ICR = 4'hc;
endpackage
`default_nettype wire

// ### test/testbench.sv
`default_nettype none
module testbench
  import timer5_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, nrst, reg_write, reg_read, timer_tick, counter_write, overflow_event, limit_event;
  logic global_irq_enable, irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, exp_flags, exp_en;
  logic [15:0] counter_value, v;
  logic [3:0] waveform_mode_field, vector_ack, irq_request, ei;
  logic [2:0] force_match, match_out, pend;
  logic [31:0] seed;
  logic [8:0] zero_addr [7];
  logic [3:0] modes [5];
  int n_fail, checks, mv [3];
  bit blk, glob, plain;
  timer5_compare_irq_regs u_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_tick(timer_tick),
    .counter_value(counter_value), .counter_write(counter_write), .overflow_event(overflow_event),
    .limit_event(limit_event), .waveform_mode_field(waveform_mode_field), .force_match(force_match),
    .match_out(match_out), .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .irq_request(irq_request), .irq(irq));
  always #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  // Read data lands only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, output logic [7:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 x = reg_rdata;
  endtask
  task automatic chk_flags();
    rd(OFS_EVENT_FLAGS, d);
    check("flags", d, exp_flags);
    ei = glob ? exp_flags[3:0] & exp_en[3:0] : 4'h0;
    check("irq_request", irq_request, ei);
    check("irq", irq, |ei);
  endtask
  // Model: hits found at one tick become flags at the next
  task automatic tick(input logic [15:0] cv);
    logic [2:0] h;
    h = 3'h0;
    for (int i = 0; i < 3; i++) if (mv[i] == cv) h[i] = 1'b1;
    if (blk) begin
      h = 3'h0;
      blk = 0;
    end
    @(posedge ref_clk);
    timer_tick <= 1'b1;
    counter_write <= 1'b0;
    counter_value <= cv;
    @(posedge ref_clk);
    timer_tick <= 1'b0;
    exp_flags[3:1] = exp_flags[3:1] | pend;
    pend = h;
    #1 check("match_out", match_out, h);
  endtask
  task automatic ack(input logic [3:0] x);
    @(posedge ref_clk);
    vector_ack <= x;
    @(posedge ref_clk);
    vector_ack <= 4'h0;
    exp_flags[3:0] = exp_flags[3:0] & ~x;
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {ref_clk, nrst, reg_write, reg_read, timer_tick, counter_write, overflow_event, limit_event} = 8'h00;
    {reg_addr, reg_wdata, counter_value, waveform_mode_field, vector_ack, force_match} = '0;
    global_irq_enable = 1'b1;
    glob = 1;
    exp_flags = 8'h00;
    exp_en = 8'h00;
    pend = 3'h0;
    seed = 32'h0000_7129;
    mv = '{0, 0, 0};
    zero_addr = '{OFS_EVENT_FLAGS, OFS_EVENT_ENABLES, OFS_CAPTURE_LOW, OFS_CAPTURE_HIGH, OFS_MATCH_C_LOW,
      OFS_EVENT_CLEAR, 9'h000};
    modes = '{MODE_NORMAL, MODE_CLEAR_ON_MATCH_OCR, MODE_CLEAR_ON_MATCH_ICR, 4'h1, 4'he};
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (zero_addr[i]) begin
      rd(zero_addr[i], d);
      check("reset value", d, 8'h00);
    end
    $display("test reset done");
    // Reserved bits drop, capture stays zero whatever is written
    wr(OFS_EVENT_ENABLES, 8'hff);
    exp_en = EVENT_MASK;
    wr(OFS_CAPTURE_HIGH, 8'h55);
    wr(OFS_CAPTURE_LOW, 8'haa);
    rd(OFS_EVENT_ENABLES, d);
    check("enables", d, EVENT_MASK);
    rd(OFS_CAPTURE_LOW, d);
    check("capture low", d, 8'h00);
    rd(OFS_CAPTURE_HIGH, d);
    check("capture high", d, 8'h00);
    // Back-to-back pair after a compare high byte dirtied the latch
    wr(OFS_MATCH_C_HIGH, 8'h5a);
    @(posedge ref_clk);
    reg_addr <= OFS_CAPTURE_LOW;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_addr <= OFS_CAPTURE_HIGH;
    #1 check("capture pair low", reg_rdata, 8'h00);
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 check("capture pair high", reg_rdata, 8'h00);
    chk_flags();
    $display("test registers done");
    for (int ch = 0; ch < 3; ch++) begin
      seed = xs(seed);
      v = seed[15:0];
      wr(OFS_MATCH_A_HIGH + 9'(2 * ch), v[15:8]);
      tick(v ^ 16'h0100);
      wr(OFS_MATCH_A_LOW + 9'(2 * ch), v[7:0]);
      mv[ch] = v;
      rd(OFS_MATCH_A_HIGH + 9'(2 * ch), d);
      check("match high", d, v[15:8]);
      rd(OFS_MATCH_A_LOW + 9'(2 * ch), d);
      check("match low", d, v[7:0]);
      tick(v);
      chk_flags();
      tick(v ^ 16'h0001);
      chk_flags();
      if (ch == 1) begin
        wr(OFS_EVENT_FLAGS, 8'h04);
        exp_flags[2] = 1'b0;
      end else begin
        ack(4'(2 << ch));
      end
      chk_flags();
    end
    $display("test compare done");
    tick(16'hffff);
    tick(16'hfffe);
    exp_flags[3:0] = 4'h0;
    wr(OFS_EVENT_FLAGS, 8'h0f);
    @(posedge ref_clk);
    force_match <= 3'b111;
    @(negedge ref_clk);
    check("forced match_out", match_out, 3'b111);
    @(posedge ref_clk);
    force_match <= 3'b000;
    tick(16'hfffe);
    tick(16'hfffe);
    chk_flags();
    $display("test force done");
    @(posedge ref_clk);
    counter_write <= 1'b1;
    blk = 1;
    // Tick right behind the counter write is the blocked one
    tick(16'(mv[2]));
    tick(16'(mv[2]) ^ 16'h0001);
    chk_flags();
    tick(16'(mv[2]));
    tick(16'(mv[2]) ^ 16'h0001);
    chk_flags();
    ack(4'h8);
    chk_flags();
    $display("test block done");
    foreach (modes[i]) begin
      plain = modes[i] == MODE_NORMAL || modes[i] == MODE_CLEAR_ON_MATCH_OCR || modes[i] == MODE_CLEAR_ON_MATCH_ICR;
      @(posedge ref_clk);
      waveform_mode_field <= modes[i];
      overflow_event <= 1'b1;
      @(posedge ref_clk);
      overflow_event <= 1'b0;
      if (plain) exp_flags[0] = 1'b1;
      chk_flags();
      wr(OFS_EVENT_FLAGS, 8'h00);
      chk_flags();
      wr(OFS_EVENT_FLAGS, 8'h01);
      exp_flags[0] = 1'b0;
      chk_flags();
      @(posedge ref_clk);
      limit_event <= 1'b1;
      @(posedge ref_clk);
      limit_event <= 1'b0;
      if (!plain) exp_flags[0] = 1'b1;
      chk_flags();
      ack(4'h1);
      chk_flags();
    end
    $display("test overflow done");
    // Flag held while the request is gated off two ways
    @(posedge ref_clk);
    overflow_event <= 1'b1;
    waveform_mode_field <= MODE_NORMAL;
    global_irq_enable <= 1'b0;
    @(posedge ref_clk);
    overflow_event <= 1'b0;
    exp_flags[0] = 1'b1;
    glob = 0;
    chk_flags();
    wr(OFS_EVENT_ENABLES, 8'h00);
    exp_en = 8'h00;
    global_irq_enable <= 1'b1;
    glob = 1;
    chk_flags();
    $display("test gating done");
    finish_test();
  end
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
